// [hw/swp_packer.sv]
// String word packer: orders a character string into device memory words.
//
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// RL1: Ordering mode register accepts values one to eight.
// RL2: Mode selects sequence, byte order, word order.
// RL3: Start modes: 4, 2, 5, 1 decode.
// RL4: End modes: 6, 7, 8, 3 decode.
// RL5: Sixteen-bit target packs two characters per word.
// RL6: Odd count on sixteen-bit pads one null.
// RL7: Thirty-two-bit target packs four characters per address.
// RL8: Incomplete group of four padded with nulls.
// RL9: Byte order picks upper or lower for earlier.
// RL10: Thirty-two-bit halves follow byte and word order.
// RL11: End storage writes last group at lowest address.
// RL12: Bytes are characters; illegal modes keep old mode.
module swp_packer #(
    parameter int MAX_CHARS = 64
) (
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic [31:0]      reg_rdata_o,
    input  wire logic        char_valid_i,
    input  wire logic [7:0]  char_data_i,
    input  wire logic        char_last_i,
    output logic             char_ready_o,
    output logic             dev_valid_o,
    input  wire logic        dev_ready_i,
    output logic [15:0]      dev_addr_o,
    output logic [31:0]      dev_data_o,
    output logic             dev_wide_o
);

    localparam int CNT_W = $clog2(MAX_CHARS + 1);
    localparam int IDX_W = CNT_W + 2;
    localparam int BUF_W = 1 + 16 + 32;

    typedef struct packed {
        swp_pkg::swp_state_e           state;
        logic [3:0]                    mode;
        logic                          wide_cfg;
        logic [15:0]                   base;
        logic [MAX_CHARS-1:0][7:0]     mem;
        logic [CNT_W-1:0]              count;
        logic [CNT_W-1:0]              groups;
        logic [CNT_W-1:0]              step;
        logic                          from_end;
        logic                          byte_hl;
        logic                          word_hl;
        logic                          wide;
        logic                          rejected;
        logic                          overflow;
        logic [15:0]                   done_cnt;
        logic [31:0]                   rdata;
    } swp_state_s;

    swp_state_s cur_r;
    swp_state_s cur_nxt;

    logic             buf_in_valid;
    logic             buf_in_ready;
    logic [BUF_W-1:0] buf_in_data;
    logic [BUF_W-1:0] buf_out_data;

    // Decodes a mode into from_end, byte high-low and word high-low.
    function automatic logic [2:0] decode_mode(input logic [3:0] m);
        logic [2:0] d;
        d = 3'h0;
        case (m)
            // RL3: start modes
            swp_pkg::MODE_S_LL: d = 3'b000;
            swp_pkg::MODE_S_LH: d = 3'b001;
            swp_pkg::MODE_S_HL: d = 3'b010;
            swp_pkg::MODE_S_HH: d = 3'b011;
            // RL4: end modes
            swp_pkg::MODE_E_LL: d = 3'b100;
            swp_pkg::MODE_E_LH: d = 3'b101;
            swp_pkg::MODE_E_HL: d = 3'b110;
            swp_pkg::MODE_E_HH: d = 3'b111;
            default:            d = 3'b000;
        endcase
        return d;
    endfunction

    // Returns a stored character, or null past the end of the string.
    function automatic logic [7:0] char_at(
        input logic [MAX_CHARS-1:0][7:0] mem,
        input logic [CNT_W-1:0]          count,
        input logic [IDX_W-1:0]          idx
    );
        logic [7:0] c;
        c = swp_pkg::NULL_CHAR;
        if (idx < IDX_W'(count)) begin
            c = mem[idx[CNT_W-1:0]];
        end
        return c;
    endfunction

    // Orders one character pair into a 16-bit half, earlier char upper when hl is set, lower when clear.
    function automatic logic [15:0] pack_half(
        input logic [7:0] early,
        input logic [7:0] later,
        input logic       hl
    );
        logic [15:0] h;
        // RL9: earlier byte placement
        h = hl ? {early, later} : {later, early};
        return h;
    endfunction

    // Emission side signals.
    logic [CNT_W-1:0] group_idx;
    logic [IDX_W-1:0] first_idx;
    logic [7:0]       c0;
    logic [7:0]       c1;
    logic [7:0]       c2;
    logic [7:0]       c3;
    logic [15:0]      half0;
    logic [15:0]      half1;
    logic [31:0]      word_data;
    logic [15:0]      word_addr;

    always_comb begin
        // RL11: reverse group walk
        if (cur_r.from_end) begin
            group_idx = cur_r.groups - 1'b1 - cur_r.step;
        end else begin
            group_idx = cur_r.step;
        end
        // RL5: two per word
        // RL7: four per address
        if (cur_r.wide) begin
            first_idx = {group_idx, 2'b00};
        end else begin
            first_idx = {1'b0, group_idx, 1'b0};
        end
        // RL6: null pads odd count
        // RL8: nulls fill group
        c0 = char_at(cur_r.mem, cur_r.count, first_idx);
        c1 = char_at(cur_r.mem, cur_r.count, first_idx + IDX_W'(1));
        c2 = char_at(cur_r.mem, cur_r.count, first_idx + IDX_W'(2));
        c3 = char_at(cur_r.mem, cur_r.count, first_idx + IDX_W'(3));
        half0 = pack_half(c0, c1, cur_r.byte_hl);
        half1 = pack_half(c2, c3, cur_r.byte_hl);
        // RL10: word order halves
        if (!cur_r.wide) begin
            word_data = {16'h0000, half0};
        end else if (cur_r.word_hl) begin
            word_data = {half0, half1};
        end else begin
            word_data = {half1, half0};
        end
        word_addr = cur_r.base + 16'(cur_r.step);
    end

    assign buf_in_valid = (cur_r.state == swp_pkg::SWP_ST_EMIT);
    assign buf_in_data  = {cur_r.wide, word_addr, word_data};
    assign char_ready_o = (cur_r.state == swp_pkg::SWP_ST_COLLECT);
    assign reg_rdata_o  = cur_r.rdata;
    assign dev_wide_o   = buf_out_data[BUF_W-1];
    assign dev_addr_o   = buf_out_data[47:32];
    assign dev_data_o   = buf_out_data[31:0];

    // Collection side temporaries.
    logic [CNT_W-1:0] count_after;
    logic [CNT_W+1:0] grp_calc;
    logic [2:0]       dec;

    always_comb begin
        cur_nxt     = cur_r;
        count_after = cur_r.count;
        grp_calc    = '0;
        dec         = decode_mode(cur_r.mode);
        cur_nxt.rdata = 32'h0000_0000;

        // Register writes.
        if (reg_wr_i) begin
            case (reg_addr_i)
                swp_pkg::REG_MODE_OFS: begin
                    // RL1: legal range check
                    // RL12: keep old mode
                    if (reg_wdata_i[31:swp_pkg::MODE_MSB+1] == 28'h000_0000 &&
                        reg_wdata_i[swp_pkg::MODE_MSB:0] >= swp_pkg::MODE_MIN &&
                        reg_wdata_i[swp_pkg::MODE_MSB:0] <= swp_pkg::MODE_MAX) begin
                        cur_nxt.mode = reg_wdata_i[swp_pkg::MODE_MSB:0];
                    end else begin
                        cur_nxt.rejected = 1'b1;
                    end
                end
                swp_pkg::REG_CFG_OFS: begin
                    cur_nxt.wide_cfg = reg_wdata_i[swp_pkg::CFG_WIDE_BIT];
                end
                swp_pkg::REG_BASE_OFS: begin
                    cur_nxt.base = reg_wdata_i[15:0];
                end
                swp_pkg::REG_STAT_OFS: begin
                    if (reg_wdata_i[swp_pkg::STAT_REJ_BIT]) begin
                        cur_nxt.rejected = 1'b0;
                    end
                    if (reg_wdata_i[swp_pkg::STAT_OVF_BIT]) begin
                        cur_nxt.overflow = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // Register reads answer in the following cycle.
        if (reg_rd_i) begin
            case (reg_addr_i)
                swp_pkg::REG_MODE_OFS: cur_nxt.rdata = {28'h000_0000, cur_r.mode};
                swp_pkg::REG_CFG_OFS:  cur_nxt.rdata = {31'h0000_0000, cur_r.wide_cfg};
                swp_pkg::REG_BASE_OFS: cur_nxt.rdata = {16'h0000, cur_r.base};
                swp_pkg::REG_STAT_OFS: begin
                    cur_nxt.rdata[swp_pkg::STAT_BUSY_BIT] =
                        (cur_r.state == swp_pkg::SWP_ST_EMIT);
                    cur_nxt.rdata[swp_pkg::STAT_REJ_BIT] = cur_r.rejected;
                    cur_nxt.rdata[swp_pkg::STAT_OVF_BIT] = cur_r.overflow;
                    cur_nxt.rdata[swp_pkg::STAT_CNT_LSB +: 16] = 16'(cur_r.count);
                end
                swp_pkg::REG_DONE_OFS: cur_nxt.rdata = {16'h0000, cur_r.done_cnt};
                default:               cur_nxt.rdata = 32'h0000_0000;
            endcase
        end

        case (cur_r.state)
            swp_pkg::SWP_ST_COLLECT: begin
                if (char_valid_i) begin
                    // RL12: one byte per character
                    if (cur_r.count < CNT_W'(MAX_CHARS)) begin
                        cur_nxt.mem[cur_r.count[CNT_W-1:0]] = char_data_i;
                        count_after = cur_r.count + 1'b1;
                        cur_nxt.count = count_after;
                    end else begin
                        // Overflow set wins over a same-cycle clear.
                        cur_nxt.overflow = 1'b1;
                    end
                    if (char_last_i && count_after != '0) begin
                        // RL2: latch three choices
                        cur_nxt.from_end = dec[2];
                        cur_nxt.byte_hl  = dec[1];
                        cur_nxt.word_hl  = dec[0];
                        cur_nxt.wide     = cur_r.wide_cfg;
                        if (cur_r.wide_cfg) begin
                            grp_calc = ((CNT_W+2)'(count_after) + (CNT_W+2)'(3)) >> 2;
                        end else begin
                            grp_calc = ((CNT_W+2)'(count_after) + (CNT_W+2)'(1)) >> 1;
                        end
                        cur_nxt.groups = grp_calc[CNT_W-1:0];
                        cur_nxt.step   = '0;
                        cur_nxt.state  = swp_pkg::SWP_ST_EMIT;
                    end
                end
            end
            swp_pkg::SWP_ST_EMIT: begin
                // A full buffer holds the word and the step in place.
                if (buf_in_ready) begin
                    if (cur_r.step == cur_r.groups - 1'b1) begin
                        cur_nxt.step     = '0;
                        cur_nxt.count    = '0;
                        cur_nxt.done_cnt = cur_r.done_cnt + 16'h0001;
                        cur_nxt.state    = swp_pkg::SWP_ST_COLLECT;
                    end else begin
                        cur_nxt.step = cur_r.step + 1'b1;
                    end
                end
            end
            default: begin
                cur_nxt.state = swp_pkg::SWP_ST_COLLECT;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cur_r          <= '0;
            cur_r.state    <= swp_pkg::SWP_ST_COLLECT;
            cur_r.mode     <= swp_pkg::MODE_RST;
            cur_r.wide_cfg <= swp_pkg::WIDE_RST;
            cur_r.base     <= swp_pkg::BASE_RST;
        end else begin
            cur_r <= cur_nxt;
        end
    end

    swp_buf2 #(
        .WIDTH (BUF_W)
    ) u_buf (
        .clk_i       (clk_i),
        .reset_n_i   (reset_n_i),
        .in_valid_i  (buf_in_valid),
        .in_ready_o  (buf_in_ready),
        .in_data_i   (buf_in_data),
        .out_valid_o (dev_valid_o),
        .out_ready_i (dev_ready_i),
        .out_data_o  (buf_out_data)
    );

endmodule

`default_nettype wire

// [include/swp_pkg.sv]
// Constants and types shared by the string word packer.
`default_nettype none

package swp_pkg;

    // Register offsets on the plain register port (byte addresses).
    localparam logic [7:0] REG_MODE_OFS = 8'h00;
    localparam logic [7:0] REG_CFG_OFS  = 8'h04;
    localparam logic [7:0] REG_BASE_OFS = 8'h08;
    localparam logic [7:0] REG_STAT_OFS = 8'h0C;
    localparam logic [7:0] REG_DONE_OFS = 8'h10;

    // Field positions.
    localparam int CFG_WIDE_BIT  = 0;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_REJ_BIT  = 1;
    localparam int STAT_OVF_BIT  = 2;
    localparam int STAT_CNT_LSB  = 8;
    localparam int MODE_MSB      = 3;

    // Reset values.
    localparam logic [3:0]  MODE_RST = 4'h4;
    localparam logic        WIDE_RST = 1'b0;
    localparam logic [15:0] BASE_RST = 16'h0000;

    // Legal ordering modes.
    localparam logic [3:0] MODE_MIN = 4'h1;
    localparam logic [3:0] MODE_MAX = 4'h8;

    // Ordering mode codes: start/end, byte order, word order.
    localparam logic [3:0] MODE_S_LL = 4'h4;
    localparam logic [3:0] MODE_S_LH = 4'h2;
    localparam logic [3:0] MODE_S_HL = 4'h5;
    localparam logic [3:0] MODE_S_HH = 4'h1;
    localparam logic [3:0] MODE_E_LL = 4'h6;
    localparam logic [3:0] MODE_E_LH = 4'h7;
    localparam logic [3:0] MODE_E_HL = 4'h8;
    localparam logic [3:0] MODE_E_HH = 4'h3;

    localparam logic [7:0] NULL_CHAR = 8'h00;

    localparam int CHARS_16 = 2;
    localparam int CHARS_32 = 4;

    typedef enum logic [1:0] {
        SWP_ST_COLLECT = 2'b01,
        SWP_ST_EMIT    = 2'b10
    } swp_state_e;

endpackage

`default_nettype wire

// [hw/swp_buf2.sv]
// Two-entry valid/ready buffer for device write words.
`timescale 1ns/100ps
`default_nettype none

module swp_buf2 #(
    parameter int WIDTH = 49
) (
    input  wire logic             clk_i,
    input  wire logic             reset_n_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);

    typedef struct packed {
        logic [1:0][WIDTH-1:0] slot;
        logic                  wr_ptr;
        logic                  rd_ptr;
        logic [1:0]            fill;
    } swp_buf_s;

    swp_buf_s cur_r;
    swp_buf_s cur_nxt;

    logic push;
    logic pop;

    assign in_ready_o  = (cur_r.fill != 2'h2);
    assign out_valid_o = (cur_r.fill != 2'h0);
    assign out_data_o  = cur_r.slot[cur_r.rd_ptr];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_comb begin
        cur_nxt = cur_r;
        if (push) begin
            cur_nxt.slot[cur_r.wr_ptr] = in_data_i;
            cur_nxt.wr_ptr             = ~cur_r.wr_ptr;
        end
        if (pop) begin
            cur_nxt.rd_ptr = ~cur_r.rd_ptr;
        end
        if (push && !pop) begin
            cur_nxt.fill = cur_r.fill + 2'h1;
        end else if (pop && !push) begin
            cur_nxt.fill = cur_r.fill - 2'h1;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cur_r <= '0;
        end else begin
            cur_r <= cur_nxt;
        end
    end

endmodule

`default_nettype wire

// [sim/swp_packer_properties.sv]
// Port checks and covers for the string word packer.
`timescale 1ns/100ps
`default_nettype none

module swp_packer_chk (
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [31:0] reg_rdata_o,
    input  wire logic        char_valid_i,
    input  wire logic [7:0]  char_data_i,
    input  wire logic        char_last_i,
    input  wire logic        char_ready_o,
    input  wire logic        dev_valid_o,
    input  wire logic        dev_ready_i,
    input  wire logic [15:0] dev_addr_o,
    input  wire logic [31:0] dev_data_o,
    input  wire logic        dev_wide_o
);
    logic [3:0] mode_sh_r;
    logic       wide_sh_r;
    logic       bad_mode;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    assign bad_mode = reg_wdata_i == 32'h0000_0000 || reg_wdata_i > 32'h0000_0008;

    // Shadow of the settings that software should read back.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mode_sh_r <= swp_pkg::MODE_RST;
            wide_sh_r <= swp_pkg::WIDE_RST;
        end else if (reg_wr_i) begin
            if (reg_addr_i == swp_pkg::REG_MODE_OFS && !bad_mode) begin
                mode_sh_r <= reg_wdata_i[3:0];
            end
            if (reg_addr_i == swp_pkg::REG_CFG_OFS) begin
                wide_sh_r <= reg_wdata_i[0];
            end
        end
    end

    a_hi_zero: assert property (dev_valid_o && !dev_wide_o |-> dev_data_o[31:16] == 16'h0000)
        else $error("narrow word has a nonzero upper half");
    a_mode_keep: assert property (reg_rd_i && reg_addr_i == swp_pkg::REG_MODE_OFS
        |=> reg_rdata_o == {28'h000_0000, mode_sh_r})
        else $error("mode readback differs from last legal write");
    a_mode_range: assert property (reg_rd_i && reg_addr_i == swp_pkg::REG_MODE_OFS
        |=> reg_rdata_o >= 32'h0000_0001 && reg_rdata_o <= 32'h0000_0008)
        else $error("mode readback outside one to eight");
    a_word_hold: assert property (dev_valid_o && !dev_ready_i
        |=> dev_valid_o && $stable(dev_data_o) && $stable(dev_addr_o) && $stable(dev_wide_o))
        else $error("stalled word changed or vanished");
    a_emit_start: assert property (char_valid_i && char_ready_o && char_last_i
        |=> !char_ready_o ##1 dev_valid_o)
        else $error("emission did not start after the last character");
    a_rej_flag: assert property (reg_wr_i && reg_addr_i == swp_pkg::REG_MODE_OFS && bad_mode
        ##1 reg_rd_i && reg_addr_i == swp_pkg::REG_STAT_OFS
        |=> reg_rdata_o[swp_pkg::STAT_REJ_BIT])
        else $error("illegal mode not flagged");
    a_rd_idle: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0000_0000)
        else $error("read data outside its cycle");
    a_wide_cfg: assert property (reg_rd_i && reg_addr_i == swp_pkg::REG_CFG_OFS
        |=> reg_rdata_o[swp_pkg::CFG_WIDE_BIT] == wide_sh_r)
        else $error("target width readback wrong");

    c_last: cover property (char_valid_i && char_ready_o && char_last_i);
    c_wide: cover property (dev_valid_o && dev_ready_i && dev_wide_o);
    c_stall: cover property (dev_valid_o && !dev_ready_i ##1 dev_valid_o && dev_ready_i);
endmodule

bind swp_packer swp_packer_chk chk_u (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .char_valid_i(char_valid_i), .char_data_i(char_data_i), .char_last_i(char_last_i),
    .char_ready_o(char_ready_o), .dev_valid_o(dev_valid_o), .dev_ready_i(dev_ready_i),
    .dev_addr_o(dev_addr_o), .dev_data_o(dev_data_o), .dev_wide_o(dev_wide_o)
);

`default_nettype wire

// [sim/swp_dev_model.sv]
// Controller memory that takes packed words, promptly or with stalls.
`timescale 1ns/100ps
`default_nettype none

module swp_dev_model (
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    input  wire logic        slow_i,
    input  wire logic        dev_valid_i,
    input  wire logic [15:0] dev_addr_i,
    input  wire logic [31:0] dev_data_i,
    input  wire logic        dev_wide_i,
    output logic             dev_ready_o
);
    logic [31:0] mem [0:255];
    logic [1:0]  tick_r;
    logic        wide_r;
    int          words = 0;

    // Unwritten cells keep a marker so stray or missing words show up.
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 32'hDEAD_BEEF;
        end
    end

    // A slow device listens only one cycle in four.
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tick_r <= 2'b00;
            wide_r <= 1'b0;
            dev_ready_o <= 1'b0;
        end else begin
            tick_r <= tick_r + 2'b01;
            dev_ready_o <= !slow_i || tick_r == 2'b11;
            if (dev_valid_i && dev_ready_o) begin
                mem[dev_addr_i[7:0]] <= dev_data_i;
                wide_r <= dev_wide_i;
                words <= words + 1;
            end
        end
    end
endmodule

`default_nettype wire

// [sim/testbench.sv]
// Self-checking bench for the string word packer.
`timescale 1ns/100ps
`default_nettype none

`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin fail_count++; \
    $display("BAD %0t got %h expected %h", $time, got, exp); end end

module testbench;
    logic        clk_i, reset_n_i, reg_wr_i, reg_rd_i, char_valid_i, char_last_i, slow;
    logic        char_ready_o, dev_valid_o, dev_ready_i, dev_wide_o;
    logic [7:0]  reg_addr_i, char_data_i;
    logic [15:0] dev_addr_o;
    logic [31:0] reg_wdata_i, reg_rdata_o, dev_data_o, d;
    logic [31:0] bad [3] = '{32'h0000_0000, 32'h0000_0009, 32'h0000_0011};
    int          fail_count = 0;
    int          tests_run = 0;
    int          cycles = 0;
    int          len, nw, n0, base, k;
    string       alpha = "ABCDEFGHIJKL";
    string       s;

    swp_packer #(.MAX_CHARS(16)) dut_u (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .char_valid_i(char_valid_i), .char_data_i(char_data_i),
        .char_last_i(char_last_i), .char_ready_o(char_ready_o), .dev_valid_o(dev_valid_o),
        .dev_ready_i(dev_ready_i), .dev_addr_o(dev_addr_o), .dev_data_o(dev_data_o),
        .dev_wide_o(dev_wide_o)
    );

    swp_dev_model m_u (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .slow_i(slow), .dev_valid_i(dev_valid_o),
        .dev_addr_i(dev_addr_o), .dev_data_i(dev_data_o), .dev_wide_i(dev_wide_o),
        .dev_ready_o(dev_ready_i)
    );

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            results();
        end
    end

    task automatic results;
        if (fail_count == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // The write strobe stays up so writes may follow each other; the next task lowers it.
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        reg_rd_i <= 1'b0;
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= v;
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1 v = reg_rdata_o;
        @(posedge clk_i);
    endtask

    task automatic send_str(input string s);
        reg_wr_i <= 1'b0;
        for (int i = 0; i < s.len(); i++) begin
            char_valid_i <= 1'b1;
            char_data_i <= s[i];
            char_last_i <= i == s.len() - 1;
            @(posedge clk_i);
            while (char_ready_o !== 1'b1) @(posedge clk_i);
        end
        char_valid_i <= 1'b0;
        char_last_i <= 1'b0;
    endtask

    // Word k counted up from the base address, for mode m and wide target w.
    function automatic logic [31:0] exp_word(input int m, input int w, input string s,
                                             input int k);
        logic [7:0]  c [4];
        logic [15:0] h0, h1;
        int          g, per;
        per = w ? 4 : 2;
        g = m inside {3, 6, 7, 8} ? (s.len() + per - 1) / per - 1 - k : k;
        for (int i = 0; i < 4; i++) begin
            c[i] = (i < per && g * per + i < s.len()) ? s[g * per + i] : 8'h00;
        end
        h0 = m inside {2, 4, 6, 7} ? {c[1], c[0]} : {c[0], c[1]};
        h1 = m inside {2, 4, 6, 7} ? {c[3], c[2]} : {c[2], c[3]};
        if (w == 0) begin
            return {16'h0000, h0};
        end
        return m inside {4, 5, 6, 8} ? {h1, h0} : {h0, h1};
    endfunction

    initial begin
        {reset_n_i, reg_wr_i, reg_rd_i, char_valid_i, char_last_i, slow} = 6'h00;
        {reg_addr_i, char_data_i, reg_wdata_i} = 48'h0000_0000_0000;
        repeat (4) @(posedge clk_i);
        reset_n_i <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            rd(8'(4 * i), d);
            `CHK(d, i == 0 ? {28'h000_0000, swp_pkg::MODE_RST} : 32'h0000_0000)
        end
        foreach (bad[i]) begin
            wr(swp_pkg::REG_MODE_OFS, bad[i]);
            rd(swp_pkg::REG_STAT_OFS, d);
            `CHK(d[swp_pkg::STAT_REJ_BIT], 1'b1)
            rd(swp_pkg::REG_MODE_OFS, d);
            `CHK(d, 32'h0000_0004)
            wr(swp_pkg::REG_STAT_OFS, 32'h0000_0001 << swp_pkg::STAT_REJ_BIT);
            rd(swp_pkg::REG_STAT_OFS, d);
            `CHK(d[swp_pkg::STAT_REJ_BIT], 1'b0)
        end
        for (int w = 0; w < 2; w++) begin
            for (int m = 1; m <= 8; m++) begin
                len = (m * 3) % 11 + 1;
                nw = w ? (len + 3) / 4 : (len + 1) / 2;
                base = 16 * (8 * w + m - 1);
                wr(swp_pkg::REG_MODE_OFS, m);
                wr(swp_pkg::REG_CFG_OFS, w);
                wr(swp_pkg::REG_BASE_OFS, base);
                slow <= m % 3 == 0;
                n0 = m_u.words;
                s = alpha.substr(0, len - 1);
                send_str(s);
                k = 0;
                while (m_u.words - n0 < nw && k < 200) begin
                    @(posedge clk_i);
                    k++;
                end
                repeat (8) @(posedge clk_i);
                for (int j = 0; j <= nw; j++) begin
                    d = j < nw ? exp_word(m, w, s, j) : 32'hDEAD_BEEF;
                    `CHK(m_u.mem[base + j], d)
                end
                `CHK(m_u.wide_r, 1'(w))
            end
        end
        // Seventeen characters into sixteen places: busy, count and overflow show up.
        send_str("ABCDEFGHIJKLMNOPQ");
        rd(swp_pkg::REG_STAT_OFS, d);
        `CHK(d, 32'h0000_1005)
        repeat (20) @(posedge clk_i);
        rd(swp_pkg::REG_STAT_OFS, d);
        `CHK(d, 32'h0000_0001 << swp_pkg::STAT_OVF_BIT)
        wr(swp_pkg::REG_STAT_OFS, 32'h0000_0001 << swp_pkg::STAT_OVF_BIT);
        rd(swp_pkg::REG_STAT_OFS, d);
        `CHK(d, 32'h0000_0000)
        rd(swp_pkg::REG_DONE_OFS, d);
        `CHK(d, 32'h0000_0011)
        results();
    end
endmodule

`undef CHK
`default_nettype wire
